// ===== include/dsac_pkg.sv
// Shared constants, register map and carrier types for the dual converter control
package dsac_pkg;

	// Register page selects
	localparam logic [7:0] PAGE_CONV0     = 8'h00;
	localparam logic [7:0] PAGE_CONV1     = 8'h01;

	// Register addresses on the special-function register bus
	localparam logic [7:0] ADDR_INPUT_MODE  = 8'hBB;
	localparam logic [7:0] ADDR_CONFIG      = 8'hBC;
	localparam logic [7:0] ADDR_REFERENCE   = 8'hD1;
	localparam logic [7:0] ADDR_CONTROL     = 8'hE8;
	localparam logic [7:0] ADDR_RESULT_LOW  = 8'hBE;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;

	// Reset values
	localparam logic [7:0] RST_INPUT_MODE = 8'h00;
	localparam logic [7:0] RST_CONFIG     = 8'hF0;
	localparam logic [7:0] RST_REFERENCE  = 8'h00;
	localparam logic [7:0] RST_CONTROL    = 8'h00;
	localparam logic [7:0] RST_RESULT     = 8'h00;

	// Field positions
	localparam int CFG_PERIOD_LSB  = 4;
	localparam int CFG_SYSCAL_BIT  = 3;
	localparam int CFG_GAIN_BIT    = 2;
	localparam int CFG_LIN_BIT     = 1;
	localparam int CFG_OFFS_BIT    = 0;
	localparam int CTL_ENABLE_BIT  = 7;
	localparam int CTL_TRACK_BIT   = 6;
	localparam int CTL_DONE_BIT    = 5;
	localparam int CTL_BUSY_BIT    = 4;
	localparam int CTL_MODE_LSB0   = 2;
	localparam int CTL_MODE_LSB1   = 1;
	localparam int CTL_WINDOW_BIT  = 1;
	localparam int IMS_DIFF_BIT    = 6;
	localparam int REF_BIAS_BIT    = 1;
	localparam int REF_BUF_BIT     = 0;

	// Writable masks; reserved bits store and read as zero
	localparam logic [7:0] MASK_INPUT_MODE = 8'h40;
	localparam logic [7:0] MASK_REFERENCE  = 8'h03;
	localparam logic [7:0] MASK_CONTROL0   = 8'hCC;
	localparam logic [7:0] MASK_CONTROL1   = 8'hCE;

	// Start modes, first converter
	localparam logic [1:0] SM0_BUSY   = 2'h0;
	localparam logic [1:0] SM0_TMR3   = 2'h1;
	localparam logic [1:0] SM0_PIN    = 2'h2;
	localparam logic [1:0] SM0_TMR2   = 2'h3;
	// Start modes, second converter
	localparam logic [2:0] SM1_BUSY   = 3'h0;
	localparam logic [2:0] SM1_TMR3   = 3'h2;
	localparam logic [2:0] SM1_PIN    = 3'h4;
	localparam logic [2:0] SM1_TMR2   = 3'h6;

	// Timing
	localparam int SYS_CLK_MHZ     = 100;
	localparam int TRACK_MIN_NS    = 280;
	localparam int TRACK_CYCLES    = (TRACK_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int SAR_BITS        = 16;
	localparam int CONV_SAR_CLOCKS = SAR_BITS + 2;
	localparam int CAL_SAR_CLOCKS  = 64;
	localparam logic [6:0] CONV_CNT = 7'(CONV_SAR_CLOCKS);
	localparam logic [6:0] CAL_CNT  = 7'(CAL_SAR_CLOCKS);
	localparam logic [6:0] TRK_CNT  = 7'(TRACK_CYCLES);

	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsac_bus_s;

	// Converter trigger inputs
	typedef struct packed {
		logic tmr2_ovf;
		logic tmr3_ovf;
		logic start_pin;
	} dsac_trig_s;

	// Sequencer phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_TRACK,
		PH_CONV,
		PH_CAL
	} dsac_phase_e;

endpackage : dsac_pkg

// ===== logic/dsac_clkdiv.sv
// SAR conversion clock divider: one tick every period plus one system clocks
`timescale 1ns/1ps
module dsac_clkdiv (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [3:0] period,
	output logic            tick
);

	logic [3:0] cnt_q;   // Position within one SAR clock
	logic [3:0] cnt_d;
	logic       wrap;

	////////////////////////////////////////////////////////////////////////
	// Divider restarts when idle so each conversion begins phase aligned
	assign wrap  = run && (cnt_q == period);
	assign cnt_d = (!run || wrap) ? 4'h0 : 4'(cnt_q + 4'h1);
	assign tick  = wrap;

	// Counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : dsac_clkdiv

// ===== logic/dsac_seq.sv
// Per-converter track, convert and calibrate sequencer
`timescale 1ns/1ps
module dsac_seq (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire logic       track_first,
	input  wire logic       conv_req,
	input  wire logic [2:0] cal_req,
	input  wire logic       sar_tick,
	output logic            busy,
	output logic [2:0]      cal_busy,
	output logic            tracking,
	output logic            running,
	output logic            done
);

	dsac_pkg::dsac_phase_e ph_q;      // Current phase
	dsac_pkg::dsac_phase_e ph_d;
	logic [6:0]            cnt_q;     // Phase length counter
	logic [6:0]            cnt_d;
	logic [2:0]            cal_q;     // Which calibration runs
	logic [2:0]            cal_d;
	logic                  idle;
	logic                  cnt_end;
	logic                  cal_go;

	////////////////////////////////////////////////////////////////////////
	// Decode; requests while busy or disabled fall on the floor
	assign idle    = (ph_q == dsac_pkg::PH_IDLE) && enable;
	assign cal_go  = idle && (cal_req != 3'h0);
	assign cnt_end = (cnt_q == 7'h00);

	// Next phase
	always_comb begin
		ph_d  = ph_q;
		cnt_d = cnt_q;
		cal_d = cal_q;
		case (ph_q)
			dsac_pkg::PH_IDLE: begin
				// Calibration has priority over a same-cycle conversion
				if (cal_go) begin
					ph_d  = dsac_pkg::PH_CAL;
					cnt_d = dsac_pkg::CAL_CNT;
					cal_d = cal_req;
				end else if (idle && conv_req) begin
					ph_d  = track_first ? dsac_pkg::PH_TRACK
						: dsac_pkg::PH_CONV;
					cnt_d = track_first ? dsac_pkg::TRK_CNT
						: dsac_pkg::CONV_CNT;
				end
			end
			dsac_pkg::PH_TRACK: begin
				// Tracking counted in system clocks
				if (cnt_end) begin
					ph_d  = dsac_pkg::PH_CONV;
					cnt_d = dsac_pkg::CONV_CNT;
				end else begin
					cnt_d = 7'(cnt_q - 7'h01);
				end
			end
			dsac_pkg::PH_CONV, dsac_pkg::PH_CAL: begin
				// Conversion and calibration counted in SAR clocks
				if (cnt_end) begin
					ph_d  = dsac_pkg::PH_IDLE;
					cal_d = 3'h0;
				end else if (sar_tick) begin
					cnt_d = 7'(cnt_q - 7'h01);
				end
			end
			default: begin
				ph_d = dsac_pkg::PH_IDLE;
			end
		endcase
		// Shutdown aborts any activity
		if (!enable) begin
			ph_d  = dsac_pkg::PH_IDLE;
			cal_d = 3'h0;
		end
	end

	// Outputs
	assign busy     = (ph_q == dsac_pkg::PH_TRACK) || (ph_q == dsac_pkg::PH_CONV);
	assign cal_busy = cal_q;
	assign tracking = enable && (ph_q == dsac_pkg::PH_TRACK
		|| (ph_q == dsac_pkg::PH_IDLE && !track_first));
	assign running  = (ph_q == dsac_pkg::PH_CONV) || (ph_q == dsac_pkg::PH_CAL);
	assign done     = (ph_q == dsac_pkg::PH_CONV) && cnt_end && enable;

	// State registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_q  <= dsac_pkg::PH_IDLE;
			cnt_q <= 7'h00;
			cal_q <= 3'h0;
		end else begin
			ph_q  <= ph_d;
			cnt_q <= cnt_d;
			cal_q <= cal_d;
		end
	end

endmodule : dsac_seq

// ===== logic/dsac_top.sv
// Top of the dual converter control: registers, trigger routing, results
`timescale 1ns/1ps

// Behaviour
// - SAR clock is period field plus one
// - System-cal bit picks internal or external
// - Gain cal starts only when idle
// - Linearity cal starts only when idle
// - Offset cal starts only when idle
// - Differential bit selects paired operation
// - Differential result goes to first converter
// - Enable bit gates shutdown versus activity
// - Track mode clear tracks continuously
// - Done flag set on busy fall, sticky
// - First busy write starts in mode 00
// - First converter start-mode trigger selection
// - Track mode: trigger tracks, pin converts
// - Second converter start-mode trigger selection
// - Second converter track-mode trigger behaviour
// - Second busy write starts in mode 000
// - Window flag set on match, sticky
// - Reference buffer enable drives reference pin
// - Reserved reference bits read zero
module dsac_top (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire dsac_pkg::dsac_bus_s bus,
	output logic [7:0]              rdata,
	input  wire dsac_pkg::dsac_trig_s trig0,
	input  wire dsac_pkg::dsac_trig_s trig1,
	input  wire logic [15:0]        sample0,
	input  wire logic [15:0]        sample1,
	input  wire logic               window0_match,
	output logic                    conv0_bias_enable,
	output logic                    conv1_bias_enable,
	output logic                    conv0_refbuf_enable,
	output logic                    conv1_refbuf_enable,
	output logic [1:0]              system_cal_select,
	output logic [1:0]              track_active,
	output logic [1:0]              done_event
);

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0]  ims_q;          // Input mode select
	logic [7:0]  cfg_q [2];      // Configuration per converter
	logic [7:0]  ref_q [2];      // Reference control per converter
	logic [7:0]  ctl_q [2];      // Control, stored fields only
	logic [1:0]  done_q;         // Sticky conversion complete flags
	logic        win_q;          // Sticky window flag, first converter
	logic [15:0] res_q [2];      // Result words
	logic [1:0]  pin_q;          // Start pin history for edge detect
	logic [7:0]  rdata_q;        // Read data register

	// Sequencer feedback
	logic [1:0]  busy;
	logic [2:0]  cal_busy [2];
	logic [1:0]  tracking;
	logic [1:0]  done;
	logic [1:0]  sar_tick;
	logic [1:0]  running;

	////////////////////////////////////////////////////////////////////////
	// Address decode, shared by read and write paths
	function automatic logic hit(input dsac_pkg::dsac_bus_s b,
		input logic [7:0] page, input logic [7:0] addr);
		hit = (b.page == page) && (b.addr == addr);
	endfunction : hit

	logic [1:0] wr_cfg;
	logic [1:0] wr_ref;
	logic [1:0] wr_ctl;
	logic [1:0] wr_rlo;
	logic [1:0] wr_rhi;
	logic       wr_ims;
	logic [7:0] page_of [2];

	assign page_of[0] = dsac_pkg::PAGE_CONV0;
	assign page_of[1] = dsac_pkg::PAGE_CONV1;
	assign wr_ims = bus.wr && hit(bus, dsac_pkg::PAGE_CONV0,
		dsac_pkg::ADDR_INPUT_MODE);

	// Busy writes of one, per converter
	logic [1:0] busy_wr1;
	logic [1:0] cal_wr;
	logic       diff_mode;
	logic [1:0] mode0;
	logic [2:0] mode1;
	logic [1:0] pin_rise;
	logic [1:0] conv_req;
	logic [1:0] track_first;

	assign diff_mode = ims_q[dsac_pkg::IMS_DIFF_BIT];
	assign mode0 = ctl_q[0][dsac_pkg::CTL_MODE_LSB0 +: 2];
	assign mode1 = ctl_q[1][dsac_pkg::CTL_MODE_LSB1 +: 3];
	assign pin_rise[0] = trig0.start_pin && !pin_q[0];
	assign pin_rise[1] = trig1.start_pin && !pin_q[1];

	////////////////////////////////////////////////////////////////////////
	// Per-converter decode, divider and sequencer
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_conv
			logic [2:0] cal_req;

			assign wr_cfg[gi] = bus.wr && hit(bus, page_of[gi],
				dsac_pkg::ADDR_CONFIG);
			assign wr_ref[gi] = bus.wr && hit(bus, page_of[gi],
				dsac_pkg::ADDR_REFERENCE);
			assign wr_ctl[gi] = bus.wr && hit(bus, page_of[gi],
				dsac_pkg::ADDR_CONTROL);
			assign wr_rlo[gi] = bus.wr && hit(bus, page_of[gi],
				dsac_pkg::ADDR_RESULT_LOW);
			assign wr_rhi[gi] = bus.wr && hit(bus, page_of[gi],
				dsac_pkg::ADDR_RESULT_HIGH);
			assign busy_wr1[gi] = wr_ctl[gi]
				&& bus.wdata[dsac_pkg::CTL_BUSY_BIT];
			// Writing zero to a calibration bit does nothing
			assign cal_req = wr_cfg[gi] ? bus.wdata[2:0] : 3'h0;
			assign cal_wr[gi] = cal_req != 3'h0;

			// Divider runs only while the SAR is clocked
			dsac_clkdiv u_div (
				.clk    (clk),
				.rst_n  (rst_n),
				.run    (running[gi]),
				.period (cfg_q[gi][dsac_pkg::CFG_PERIOD_LSB +: 4]),
				.tick   (sar_tick[gi])
			);

			dsac_seq u_seq (
				.clk         (clk),
				.rst_n       (rst_n),
				.enable      (ctl_q[gi][dsac_pkg::CTL_ENABLE_BIT]),
				.track_first (track_first[gi]),
				.conv_req    (conv_req[gi]),
				.cal_req     (cal_req),
				.sar_tick    (sar_tick[gi]),
				.busy        (busy[gi]),
				.cal_busy    (cal_busy[gi]),
				.tracking    (tracking[gi]),
				.running     (running[gi]),
				.done        (done[gi])
			);

			assign system_cal_select[gi] =
				cfg_q[gi][dsac_pkg::CFG_SYSCAL_BIT];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Trigger selection, first converter
	logic trk0;
	logic trk1;
	assign trk0 = ctl_q[0][dsac_pkg::CTL_TRACK_BIT];
	assign trk1 = ctl_q[1][dsac_pkg::CTL_TRACK_BIT];

	always_comb begin
		case (mode0)
			dsac_pkg::SM0_BUSY: conv_req[0] = busy_wr1[0];
			dsac_pkg::SM0_TMR3: conv_req[0] = trig0.tmr3_ovf;
			dsac_pkg::SM0_PIN:  conv_req[0] = pin_rise[0];
			dsac_pkg::SM0_TMR2: conv_req[0] = trig0.tmr2_ovf;
			default:            conv_req[0] = 1'b0;
		endcase
	end
	// Pin mode converts at the edge; the pin low time was the track phase
	assign track_first[0] = trk0 && (mode0 != dsac_pkg::SM0_PIN);

	// Trigger selection, second converter; odd modes start on a busy write to the first
	always_comb begin
		if (mode1[0]) begin
			conv_req[1] = busy_wr1[0];
		end else begin
			case (mode1)
				dsac_pkg::SM1_BUSY: conv_req[1] = busy_wr1[1];
				dsac_pkg::SM1_TMR3: conv_req[1] = trig1.tmr3_ovf;
				dsac_pkg::SM1_PIN:  conv_req[1] = pin_rise[1];
				dsac_pkg::SM1_TMR2: conv_req[1] = trig1.tmr2_ovf;
				default:            conv_req[1] = 1'b0;
			endcase
		end
	end
	assign track_first[1] = trk1 && (mode1 != dsac_pkg::SM1_PIN);

	assign track_active = tracking;
	assign done_event   = done;

	////////////////////////////////////////////////////////////////////////
	// Result words; differential result is a signed difference
	logic [15:0] diff_word;
	logic [16:0] diff_full;
	assign diff_full = {1'b0, sample0} - {1'b0, sample1};
	// Halve the 17-bit difference so full scale fits in 16 bits
	assign diff_word = diff_full[16:1];

	////////////////////////////////////////////////////////////////////////
	// Mirrored bits for read-back
	logic [7:0] ctl_rd [2];
	logic [7:0] cfg_rd [2];
	generate
		for (gi = 0; gi < 2; gi++) begin : g_rd
			assign ctl_rd[gi] = ctl_q[gi]
				| ({7'h00, done_q[gi]} << dsac_pkg::CTL_DONE_BIT)
				| ({7'h00, busy[gi]} << dsac_pkg::CTL_BUSY_BIT);
			assign cfg_rd[gi] = {cfg_q[gi][7:3], cal_busy[gi]};
		end
	endgenerate

	// Read mux; unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < 2; i++) begin
			if (hit(bus, page_of[i], dsac_pkg::ADDR_CONFIG))
				rd_mux = cfg_rd[i];
			if (hit(bus, page_of[i], dsac_pkg::ADDR_REFERENCE))
				rd_mux = ref_q[i];
			if (hit(bus, page_of[i], dsac_pkg::ADDR_CONTROL))
				rd_mux = ctl_rd[i];
			if (hit(bus, page_of[i], dsac_pkg::ADDR_RESULT_LOW))
				rd_mux = res_q[i][7:0];
			if (hit(bus, page_of[i], dsac_pkg::ADDR_RESULT_HIGH))
				rd_mux = res_q[i][15:8];
		end
		if (hit(bus, dsac_pkg::PAGE_CONV0, dsac_pkg::ADDR_INPUT_MODE))
			rd_mux = ims_q;
		if (hit(bus, dsac_pkg::PAGE_CONV0, dsac_pkg::ADDR_CONTROL)
			&& win_q)
			rd_mux = rd_mux | 8'h02;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration, reference and mode registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ims_q <= dsac_pkg::RST_INPUT_MODE;
			for (int i = 0; i < 2; i++) begin
				cfg_q[i] <= dsac_pkg::RST_CONFIG;
				ref_q[i] <= dsac_pkg::RST_REFERENCE;
				ctl_q[i] <= dsac_pkg::RST_CONTROL;
			end
		end else begin
			if (wr_ims)
				ims_q <= bus.wdata & dsac_pkg::MASK_INPUT_MODE;
			for (int i = 0; i < 2; i++) begin
				// Calibration bits are not stored; they mirror activity
				if (wr_cfg[i])
					cfg_q[i] <= {bus.wdata[7:3], 3'h0};
				if (wr_ref[i])
					ref_q[i] <= bus.wdata & dsac_pkg::MASK_REFERENCE;
			end
			if (wr_ctl[0])
				ctl_q[0] <= bus.wdata & dsac_pkg::MASK_CONTROL0;
			if (wr_ctl[1])
				ctl_q[1] <= bus.wdata & dsac_pkg::MASK_CONTROL1;
		end
	end

	// Sticky flags: hardware set wins over a same-cycle software clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_q <= 2'h0;
			win_q  <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (done[i])
					done_q[i] <= 1'b1;
				else if (wr_ctl[i])
					done_q[i] <= bus.wdata[dsac_pkg::CTL_DONE_BIT];
			end
			if (window0_match)
				win_q <= 1'b1;
			else if (wr_ctl[0])
				win_q <= bus.wdata[dsac_pkg::CTL_WINDOW_BIT];
		end
	end

	// Result capture at end of conversion; software may also write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			res_q[0] <= {dsac_pkg::RST_RESULT, dsac_pkg::RST_RESULT};
			res_q[1] <= {dsac_pkg::RST_RESULT, dsac_pkg::RST_RESULT};
		end else begin
			if (done[0])
				res_q[0] <= diff_mode ? diff_word : sample0;
			else if (wr_rlo[0])
				res_q[0][7:0] <= bus.wdata;
			else if (wr_rhi[0])
				res_q[0][15:8] <= bus.wdata;
			if (done[1])
				res_q[1] <= sample1;
			else if (wr_rlo[1])
				res_q[1][7:0] <= bus.wdata;
			else if (wr_rhi[1])
				res_q[1][15:8] <= bus.wdata;
		end
	end

	// Read data and pin history
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
			pin_q   <= 2'h0;
		end else begin
			rdata_q <= bus.rd ? rd_mux : rdata_q;
			pin_q   <= {trig1.start_pin, trig0.start_pin};
		end
	end

	assign rdata               = rdata_q;
	assign conv0_bias_enable   = ref_q[0][dsac_pkg::REF_BIAS_BIT];
	assign conv1_bias_enable   = ref_q[1][dsac_pkg::REF_BIAS_BIT];
	assign conv0_refbuf_enable = ref_q[0][dsac_pkg::REF_BUF_BIT];
	assign conv1_refbuf_enable = ref_q[1][dsac_pkg::REF_BUF_BIT];

	// Unused-warning guard: calibration write strobe observed for debug
	logic unused_cal;
	assign unused_cal = ^cal_wr;

endmodule : dsac_top

// ===== sim/dsac_partner.sv
// Timer overflows and convert-start pins facing the converters
`timescale 1ns/1ps
module dsac_partner (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic [5:0]     fire,
	output dsac_pkg::dsac_trig_s trig0,
	output dsac_pkg::dsac_trig_s trig1
);
	logic [5:0] ovf_q;  // Timer overflow pulses, one cycle each
	logic [2:0] pin0_q; // Pin held high three cycles, one rising edge
	logic [2:0] pin1_q;
	////////////////////////////////////////////////////////////////////
	// Overflows last one cycle; pins rise once and drop back low
	always_ff @(posedge clk) begin
		ovf_q  <= rst_n ? fire : 6'h00;
		pin0_q <= !rst_n ? 3'h0 : fire[0] ? 3'h7 : pin0_q >> 1;
		pin1_q <= !rst_n ? 3'h0 : fire[3] ? 3'h7 : pin1_q >> 1;
	end
	assign trig0 = '{ovf_q[2], ovf_q[1], pin0_q[0]};
	assign trig1 = '{ovf_q[5], ovf_q[4], pin1_q[0]};
endmodule : dsac_partner

// ===== sim/dsac_top_assertions.sv
// Port-level assertions for the dual converter control
`timescale 1ns/1ps
module dsac_top_assertions (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire dsac_pkg::dsac_bus_s bus,
	input wire logic [7:0]          rdata,
	input wire logic                conv0_bias_enable,
	input wire logic                conv0_refbuf_enable,
	input wire logic                conv1_refbuf_enable,
	input wire logic [1:0]          system_cal_select,
	input wire logic [1:0]          track_active,
	input wire logic [1:0]          done_event
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////
	// Write decodes, named to keep the properties short
	wire logic ref_hit;
	wire logic cfg_hit;
	assign ref_hit = bus.wr && bus.addr == dsac_pkg::ADDR_REFERENCE;
	assign cfg_hit = bus.wr && bus.addr == dsac_pkg::ADDR_CONFIG;
	////////////////////////////////////////////////////////////////////
	a_reset_clears: assert property ($rose(rst_n) |->
		!conv0_bias_enable && !conv0_refbuf_enable && track_active == 2'h0
		&& done_event == 2'h0 && rdata == 8'h00)
		else $error("outputs not cleared by reset");
	a_ref0_write: assert property (ref_hit && bus.page == 8'h00 |=>
		{conv0_bias_enable, conv0_refbuf_enable} == $past(bus.wdata[1:0]))
		else $error("reference 0 outputs wrong after write");
	a_ref1_write: assert property (ref_hit && bus.page == 8'h01 |=>
		conv1_refbuf_enable == $past(bus.wdata[0]))
		else $error("reference 1 buffer wrong after write");
	a_syscal0_write: assert property (cfg_hit && bus.page == 8'h00 |=>
		system_cal_select[0] == $past(bus.wdata[3]))
		else $error("system cal select 0 wrong");
	a_syscal1_write: assert property (cfg_hit && bus.page == 8'h01 |=>
		system_cal_select[1] == $past(bus.wdata[3]))
		else $error("system cal select 1 wrong");
	a_done_pulse: assert property (done_event[0] |=>
		!done_event[0] [*8])
		else $error("done event not a single pulse");
	a_done_not_track: assert property (done_event[1] |->
		!track_active[1])
		else $error("tracking while conversion ends");
	a_ref_read_zero: assert property ($past(bus.rd) &&
		$past(bus.addr) == dsac_pkg::ADDR_REFERENCE |-> rdata[7:2] == 6'h00)
		else $error("reserved reference bits not zero");
	a_unmapped_zero: assert property ($past(bus.rd) &&
		$past(bus.addr) == 8'h55 |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	// Main scenarios reached
	c_done0: cover property (done_event[0]);
	c_done1: cover property (done_event[1]);
	c_bias0: cover property ($rose(conv0_bias_enable));
endmodule : dsac_top_assertions

// ===== sim/dual_sar_adc_control_tb_top.sv
// Self-checking bench for the dual converter control
`timescale 1ns/1ps
module dual_sar_adc_control_tb_top;
	logic                 clk;
	logic                 rst_n;
	dsac_pkg::dsac_bus_s  bus;
	dsac_pkg::dsac_trig_s trig0;
	dsac_pkg::dsac_trig_s trig1;
	logic [7:0]           rdata;
	logic [15:0]          sample0;
	logic [15:0]          sample1;
	logic                 window0_match;
	logic [5:0]           fire;      // Partner trigger requests
	logic [1:0]           pins0;     // Bias and buffer, converter 0
	logic                 b1;
	logic                 r1;
	logic [1:0]           scal;
	logic [1:0]           trk;
	logic [1:0]           done;
	int                   errors;
	int                   compares;
	int                   n;
	logic [3:0]           per;       // SAR clock period field
	logic [7:0]           v;         // Last read value
	logic [7:0]           d;
	logic [15:0]          w;
	logic [2:0]           m1 [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1};
	logic [5:0]           f1 [5] = '{6'h00, 6'h10, 6'h08, 6'h20, 6'h00};
	localparam logic [7:0] CT = dsac_pkg::ADDR_CONTROL;
	localparam logic [7:0] CF = dsac_pkg::ADDR_CONFIG;
	dsac_top i_dsac_top (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.trig0(trig0), .trig1(trig1), .sample0(sample0), .sample1(sample1),
		.window0_match(window0_match), .conv0_bias_enable(pins0[1]),
		.conv1_bias_enable(b1), .conv0_refbuf_enable(pins0[0]),
		.conv1_refbuf_enable(r1), .system_cal_select(scal),
		.track_active(trk), .done_event(done));
	dsac_partner i_dsac_partner (.clk(clk), .rst_n(rst_n), .fire(fire),
		.trig0(trig0), .trig1(trig1));
	////////////////////////////////////////////////////////////////////
	// Bus cycles: one-cycle strobes, a gap before the next request
	task automatic wr(input logic [7:0] p, input logic [7:0] a,
		input logic [7:0] x);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, p, a, x};
		@(posedge clk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] a);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, p, a, 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 v = rdata;
	endtask : rd
	task automatic pulse(input logic [5:0] f);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= '0;
	endtask : pulse
	// Bounded wait for the end-of-conversion pulse
	task automatic wdone(input int i, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done[i] !== 1'b1 && n < lim);
	endtask : wdone
	function automatic void chk(string s, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endfunction : chk
	// Combined differential word: half the 17-bit difference
	function automatic logic [15:0] dword(logic [15:0] a, logic [15:0] b);
		logic [16:0] x;
		x = {1'b0, a} - {1'b0, b};
		return x[16:1];
	endfunction : dword
	task automatic rd16(input logic [7:0] p);
		rd(p, dsac_pkg::ADDR_RESULT_LOW);
		w[7:0] = v;
		rd(p, dsac_pkg::ADDR_RESULT_HIGH);
		w[15:8] = v;
	endtask : rd16
	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		final_report();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h2E809D4B));
		{bus, fire, window0_match, sample0, sample1, rst_n} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (logic [7:0] p = 0; p < 2; p++) begin
			rd(p, CF);
			chk("cfg_reset", 16'hF0, v);
			rd(p, CT);
			chk("ctl_reset", 16'h00, v);
		end
		rd(8'h00, 8'h55);
		chk("unmapped", 16'h00, v);
		// Random reference settings, reserved bits kept zero
		for (int k = 0; k < 6; k++) begin
			d = {6'h00, 2'($urandom())};
			wr(8'(k % 2), dsac_pkg::ADDR_REFERENCE, d);
			rd(8'(k % 2), dsac_pkg::ADDR_REFERENCE);
			chk("ref_read", d, v);
			chk("ref_pins", d[1:0], k % 2 ? {b1, r1} : pins0);
		end
		wr(8'h00, dsac_pkg::ADDR_REFERENCE, 8'h03);
		wr(8'h01, dsac_pkg::ADDR_REFERENCE, 8'h03);
		per = 4'(3 + $urandom_range(4));
		d = {per, 1'($urandom()), 3'h0};
		wr(8'h00, CF, d);
		wr(8'h01, CF, d ^ 8'h08);
		rd(8'h01, CF);
		chk("cfg_read", d ^ 8'h08, v);
		chk("syscal", {~d[3], d[3]}, scal);
		// Converter 0: plain start, a second start while busy
		wr(8'h00, CT, 8'h80);
		#1 chk("tracking", 1, trk[0]);
		sample0 <= 16'($urandom());
		wr(8'h00, CT, 8'h90);
		wr(8'h00, CT, 8'h90);
		wdone(0, 400);
		chk("conv_len", 1, n + 2 >= 18 * (per + 1)
			&& n + 2 <= 19 * (per + 1) + 4);
		wdone(0, 300);
		chk("second_start", 0, done[0]);
		rd(8'h00, CT);
		chk("done_busy", 16'h2, v[5:4]);
		rd16(8'h00);
		chk("result0", sample0, w);
		// Other start modes: busy write refused, source accepted
		for (int m = 1; m < 4; m++) begin
			wr(8'h00, CT, 8'h80 | 8'(m << 2));
			wr(8'h00, CT, 8'h90 | 8'(m << 2));
			wdone(0, 300);
			chk("busy_refused", 0, done[0]);
			pulse(m == 1 ? 6'h02 : m == 2 ? 6'h01 : 6'h04);
			wdone(0, 400);
			chk("mode_start0", 1, done[0]);
		end
		// Window flag sticks until written to zero
		@(posedge clk) window0_match <= 1'b1;
		@(posedge clk) window0_match <= 1'b0;
		rd(8'h00, CT);
		chk("window_set", 1, v[1]);
		wr(8'h00, CT, 8'h80);
		rd(8'h00, CT);
		chk("window_clr", 0, v[1]);
		// Disabled converter does not track or start
		wr(8'h00, CT, 8'h00);
		#1 chk("off_track", 0, trk[0]);
		wr(8'h00, CT, 8'h10);
		wdone(0, 300);
		chk("off_start", 0, done[0]);
		// Converter 1 in every start mode
		wr(8'h00, CT, 8'h80);
		for (int k = 0; k < 5; k++) begin
			wr(8'h01, CT, 8'h80 | {4'h0, m1[k], 1'b0});
			if (k == 0) begin
				wr(8'h01, CT, 8'h90);
			end else if (k == 4) begin
				wr(8'h00, CT, 8'h90);
			end else begin
				pulse(f1[k]);
			end
			wdone(1, 400);
			chk("mode_start1", 1, done[1]);
		end
		// Track mode: tracking period comes before the conversion
		wr(8'h00, CT, 8'hC0);
		#1 chk("trk_hold", 0, trk[0]);
		wr(8'h00, CT, 8'hD0);
		wdone(0, 600);
		chk("track_len", 1, n + 1 >= 28 + 18 * (per + 1));
		// Differential pair result
		wr(8'h00, dsac_pkg::ADDR_INPUT_MODE, 8'h40);
		rd(8'h00, dsac_pkg::ADDR_INPUT_MODE);
		chk("diff_sel", 16'h40, v);
		sample0 <= 16'($urandom());
		sample1 <= 16'($urandom());
		wr(8'h01, CT, 8'h82);
		wr(8'h00, CT, 8'h90);
		wdone(0, 400);
		repeat (4) @(posedge clk);
		rd16(8'h00);
		chk("diff_word", dword(sample0, sample1), w);
		rd16(8'h01);
		chk("single1", sample1, w);
		// Calibrations on both converters; zero writes leave them
		for (int k = 0; k < 6; k++) begin
			wr(8'(k / 3), CF, {per, 4'(1 << (k % 3))});
			wr(8'(k / 3), CF, {per, 4'h0});
			rd(8'(k / 3), CF);
			chk("cal_running", 1, v[k % 3]);
			for (int t = 0; t < 800 && v[k % 3]; t++) begin
				rd(8'(k / 3), CF);
			end
			chk("cal_ended", 0, v[k % 3]);
		end
		final_report();
	end
endmodule : dual_sar_adc_control_tb_top
bind dsac_top dsac_top_assertions i_dsac_top_assertions (.clk(clk),
	.rst_n(rst_n), .bus(bus), .rdata(rdata),
	.conv0_bias_enable(conv0_bias_enable),
	.conv0_refbuf_enable(conv0_refbuf_enable),
	.conv1_refbuf_enable(conv1_refbuf_enable),
	.system_cal_select(system_cal_select),
	.track_active(track_active), .done_event(done_event));
